// ===== verilog/hla_lane_ctrl.sv
`timescale 1ns/1ps
module hla_lane_ctrl (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          word_clock,
    input  wire logic                          lane_lock,
    input  wire logic [hla_pkg::TAP_W-1:0]     final_tap_readback,
    input  wire logic [hla_pkg::WORD_W-1:0]    rx_word,
    input  wire hla_pkg::hla_user_cmd_type     cmd,
    output hla_pkg::hla_lane_ctl_type          lane_ctl,
    output logic                               locked,
    output logic [hla_pkg::TAP_W-1:0]          tap_value,
    output logic                               tap_valid,
    output logic [hla_pkg::WORD_W-1:0]         rx_data,
    output logic                               rx_valid,
    output logic                               step_done,
    output logic                               lock_timeout,
    output logic                               busy
);
    // ****************************************
    // Inputs from the lane domain
    // ****************************************
    localparam int unsigned SW = 2 + hla_pkg::TAP_W + hla_pkg::WORD_W;
    logic [SW-1:0] sync_q;
    logic          wclk_s;
    logic          lock_s;
    logic [hla_pkg::TAP_W-1:0]  tap_s;
    logic [hla_pkg::WORD_W-1:0] rxw_s;

    hla_sync #(.W(SW)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({word_clock, lane_lock, final_tap_readback, rx_word}),
        .sync_out (sync_q)
    );
    assign {wclk_s, lock_s, tap_s, rxw_s} = sync_q;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        hla_pkg::hla_state_type        state;
        logic [1:0]                    mode;
        logic                          wclk_d;
        logic [hla_pkg::CNT_W-1:0]     cnt;
        logic                          hold_dir;
        hla_pkg::hla_lane_ctl_type     ctl;
        logic                          locked;
        logic [hla_pkg::TAP_W-1:0]     tap;
        logic                          tap_valid;
        logic [hla_pkg::WORD_W-1:0]    rx_data;
        logic                          rx_valid;
        logic                          step_done;
        logic                          timeout;
        logic [hla_pkg::CNT_W-1:0]     tx_clr_cnt;
        logic [hla_pkg::CNT_W-1:0]     rx_clr_cnt;
        logic                          busy;
    } hla_ctrl_st_type;

    hla_ctrl_st_type st;
    hla_ctrl_st_type next_st;
    logic            wrise;

    function automatic logic [hla_pkg::CNT_W-1:0] dec_sat(
        input logic [hla_pkg::CNT_W-1:0] v);
        dec_sat = (v == '0) ? v : v - 11'h001;
    endfunction

    assign wrise = wclk_s & ~st.wclk_d;

    always_comb begin
        next_st           = st;
        next_st.wclk_d    = wclk_s;
        next_st.step_done = 1'b0;
        next_st.rx_valid  = 1'b0;
        // Lane inputs change only at word clock edges; drive on our sampled rise
        if (wrise) begin
            next_st.ctl.tx_word = cmd.tx_word;
            next_st.rx_data     = rxw_s;
            next_st.rx_valid    = 1'b1;
            next_st.tx_clr_cnt  = dec_sat(st.tx_clr_cnt);
            next_st.rx_clr_cnt  = dec_sat(st.rx_clr_cnt);
        end
        // Clears held several word clocks so the slow lane domain sees them
        if (cmd.tx_clear_req) begin
            next_st.tx_clr_cnt = 11'(hla_pkg::CLEAR_LEN);
        end
        if (cmd.rx_clear_req) begin
            next_st.rx_clr_cnt = 11'(hla_pkg::CLEAR_LEN);
        end
        next_st.ctl.serializer_clear = (next_st.tx_clr_cnt != '0);
        next_st.ctl.rx_path_clear    = (next_st.rx_clr_cnt != '0);
        case (st.state)
            hla_pkg::ST_IDLE: begin
                next_st.ctl.step_enable   = 1'b0;
                next_st.ctl.counter_clear = 1'b0;
                if (cmd.go) begin
                    next_st.mode     = cmd.mode;
                    next_st.locked   = 1'b0;
                    next_st.tap_valid = 1'b0;
                    next_st.timeout  = 1'b0;
                    next_st.cnt      = 11'(hla_pkg::CLEAR_LEN);
                    next_st.state    = hla_pkg::ST_CLEAR;
                end else if (cmd.clear_req) begin
                    // Keeps the latched mode, so an aligner retrains after it
                    next_st.locked    = 1'b0;
                    next_st.tap_valid = 1'b0;
                    next_st.cnt       = 11'(hla_pkg::CLEAR_LEN);
                    next_st.state     = hla_pkg::ST_CLEAR;
                end else if (cmd.step_req && st.mode == hla_pkg::MODE_DYNAMIC) begin
                    next_st.hold_dir = cmd.step_dir;
                    next_st.cnt      = 11'(hla_pkg::STEP_LEN);
                    next_st.state    = hla_pkg::ST_STEP;
                end
            end
            hla_pkg::ST_CLEAR: begin
                next_st.ctl.counter_clear = 1'b1;
                next_st.locked = 1'b0;
                if (wrise) begin
                    next_st.cnt = st.cnt - 11'h001;
                    if (st.cnt == 11'h001) begin
                        next_st.ctl.counter_clear = 1'b0;
                        next_st.cnt = 11'(hla_pkg::LOCK_WAIT);
                        next_st.state = (st.mode == hla_pkg::MODE_ALIGN) ?
                                        hla_pkg::ST_TRAIN : hla_pkg::ST_IDLE;
                    end
                end
            end
            hla_pkg::ST_TRAIN: begin
                // Enable runs the aligner; direction is meaningless here
                next_st.ctl.step_enable = 1'b1;
                next_st.ctl.step_up     = 1'b0;
                if (lock_s) begin
                    next_st.locked = 1'b1;
                    next_st.tap    = tap_s;
                    next_st.tap_valid = 1'b1;
                    next_st.state  = hla_pkg::ST_LOCK;
                end else if (wrise) begin
                    next_st.cnt = st.cnt - 11'h001;
                    if (st.cnt == 11'h001) begin
                        next_st.timeout = 1'b1;
                        next_st.ctl.step_enable = 1'b0;
                        next_st.state = hla_pkg::ST_IDLE;
                    end
                end
            end
            hla_pkg::ST_LOCK: begin
                next_st.tap = tap_s;
                if (!lock_s) begin
                    next_st.locked = 1'b0;
                    next_st.tap_valid = 1'b0;
                    next_st.cnt = 11'(hla_pkg::LOCK_WAIT);
                    next_st.state = hla_pkg::ST_TRAIN;
                end else if (cmd.go) begin
                    next_st.locked = 1'b0;
                    next_st.tap_valid = 1'b0;
                    next_st.timeout = 1'b0;
                    next_st.ctl.step_enable = 1'b0;
                    next_st.mode = cmd.mode;
                    next_st.cnt = 11'(hla_pkg::CLEAR_LEN);
                    next_st.state = hla_pkg::ST_CLEAR;
                end
            end
            hla_pkg::ST_STEP: begin
                // One step: enable high for exactly one word clock period
                next_st.ctl.step_up = st.hold_dir;
                if (wrise) begin
                    next_st.cnt = st.cnt - 11'h001;
                    next_st.ctl.step_enable = (st.cnt == 11'(hla_pkg::STEP_LEN));
                    if (st.cnt == 11'h001) begin
                        next_st.ctl.step_enable = 1'b0;
                        next_st.step_done = 1'b1;
                        next_st.state = hla_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_st.state = hla_pkg::ST_IDLE;
            end
        endcase
        next_st.busy = (next_st.state != hla_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.state <= hla_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign lane_ctl     = st.ctl;
    assign locked       = st.locked;
    assign tap_value    = st.tap;
    assign tap_valid    = st.tap_valid;
    assign rx_data      = st.rx_data;
    assign rx_valid     = st.rx_valid;
    assign step_done    = st.step_done;
    assign lock_timeout = st.timeout;
    assign busy         = st.busy;

    // ****************************************
    // Checks
    // ****************************************
    property p_lock_needs_lane;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(st.locked) |-> $past(lock_s) && $past(st.state) == hla_pkg::ST_TRAIN;
    endproperty
    a_lock_needs_lane: assert property (p_lock_needs_lane)
        else $error("locked rose without lane lock");

    property p_enable_in_train;
        @(posedge sys_clk) disable iff (!rst_n)
        st.state == hla_pkg::ST_TRAIN |-> ##1 st.ctl.step_enable || st.state != hla_pkg::ST_TRAIN;
    endproperty
    a_enable_in_train: assert property (p_enable_in_train)
        else $error("aligner not enabled while training");

    property p_dir_stable;
        @(posedge sys_clk) disable iff (!rst_n)
        st.ctl.step_enable && st.state == hla_pkg::ST_STEP |-> st.ctl.step_up == st.hold_dir;
    endproperty
    a_dir_stable: assert property (p_dir_stable)
        else $error("step direction wrong during step");

    property p_clear_seen;
        @(posedge sys_clk) disable iff (!rst_n)
        st.state == hla_pkg::ST_IDLE && cmd.go |-> ##2 st.ctl.counter_clear;
    endproperty
    a_clear_seen: assert property (p_clear_seen)
        else $error("counter clear not raised after go");

    property p_tap_valid_locked;
        @(posedge sys_clk) disable iff (!rst_n)
        st.tap_valid |-> st.locked && st.tap == $past(tap_s);
    endproperty
    a_tap_valid_locked: assert property (p_tap_valid_locked)
        else $error("tap valid without lock");

    property p_tx_word;
        @(posedge sys_clk) disable iff (!rst_n)
        wrise |=> st.ctl.tx_word == $past(cmd.tx_word);
    endproperty
    a_tx_word: assert property (p_tx_word)
        else $error("tx word not taken at word edge");

    property p_ser_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.tx_clear_req |=> st.ctl.serializer_clear [*2];
    endproperty
    a_ser_clear: assert property (p_ser_clear)
        else $error("serializer clear too short");

    property p_rx_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.rx_clear_req |=> st.ctl.rx_path_clear;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("rx clear not raised");

    property p_lock_low_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        st.ctl.counter_clear |-> !st.locked;
    endproperty
    a_lock_low_clear: assert property (p_lock_low_clear)
        else $error("lock high during aligner reset");

    property p_step_refused;
        @(posedge sys_clk) disable iff (!rst_n)
        st.state == hla_pkg::ST_IDLE && cmd.step_req && !cmd.go && !cmd.clear_req &&
            st.mode != hla_pkg::MODE_DYNAMIC |=> st.state == hla_pkg::ST_IDLE;
    endproperty
    a_step_refused: assert property (p_step_refused)
        else $error("step accepted outside dynamic mode");

    property p_enable_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        st.state == hla_pkg::ST_IDLE |-> !st.ctl.step_enable;
    endproperty
    a_enable_idle: assert property (p_enable_idle)
        else $error("step enable high while idle");

    property p_timeout_train;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(st.timeout) |-> $past(st.state) == hla_pkg::ST_TRAIN && !st.locked;
    endproperty
    a_timeout_train: assert property (p_timeout_train)
        else $error("timeout outside training or with lock");

    property p_rx_word;
        @(posedge sys_clk) disable iff (!rst_n)
        wrise |=> st.rx_valid && st.rx_data == $past(rxw_s);
    endproperty
    a_rx_word: assert property (p_rx_word)
        else $error("received word not taken at word edge");

    property p_step_once;
        @(posedge sys_clk) disable iff (!rst_n)
        st.step_done |-> !st.ctl.step_enable && st.state == hla_pkg::ST_IDLE;
    endproperty
    a_step_once: assert property (p_step_once)
        else $error("step enable still high at step done");

    c_lock: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(st.locked));
    c_step: cover property (@(posedge sys_clk) disable iff (!rst_n) st.step_done);
    c_tout: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(st.timeout));
    c_refuse: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st.state == hla_pkg::ST_IDLE && cmd.step_req && st.mode != hla_pkg::MODE_DYNAMIC);
    c_tx_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(st.ctl.serializer_clear));
endmodule

// ===== verilog/hla_pkg.sv
// Contract
// - Controller drives step enable in word domain
// - Step up when 1, down when 0
// - Controller supplies transmit word, up to ten
// - Protocol logic lives outside the lane
// - Data lanes clocked only within group
// - One clock lane, 1/2/4/8 data lanes
// - Up to eighteen receive channels
// - At most eight data lanes per channel
// - Transmitter initiates all communication
// - One transmit lane may be bidirectional
// - Receive clock lane position is dedicated
// - Same serialization factor both directions
package hla_pkg;
    localparam int unsigned WORD_W      = 10;
    localparam int unsigned TAP_W       = 6;
    localparam int unsigned HS_FACTOR   = 8;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CLEAR_LEN   = 4;
    localparam int unsigned LOCK_WAIT   = 1024;
    localparam int unsigned CNT_W       = 11;
    localparam int unsigned STEP_LEN    = 2;
    localparam int unsigned MAX_LANES   = 8;
    localparam int unsigned MAX_CHANNELS = 18;
    localparam logic [1:0] MODE_STATIC  = 2'h0;
    localparam logic [1:0] MODE_DYNAMIC = 2'h1;
    localparam logic [1:0] MODE_ALIGN   = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CLEAR = 5'h02,
        ST_TRAIN = 5'h04,
        ST_LOCK  = 5'h08,
        ST_STEP  = 5'h10
    } hla_state_type;

    typedef struct packed {
        logic             step_enable;
        logic             step_up;
        logic             counter_clear;
        logic             serializer_clear;
        logic             rx_path_clear;
        logic [WORD_W-1:0] tx_word;
    } hla_lane_ctl_type;

    typedef struct packed {
        logic [1:0]        mode;
        logic              go;
        logic              step_req;
        logic              step_dir;
        logic              clear_req;
        logic              tx_clear_req;
        logic              rx_clear_req;
        logic [WORD_W-1:0] tx_word;
    } hla_user_cmd_type;
endpackage

// ===== verilog/hla_sync.sv
`timescale 1ns/1ps
module hla_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hla_sync_st_type;

    hla_sync_st_type st;
    hla_sync_st_type next_st;

    always_comb begin
        next_st        = st;
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule

// ===== tb/hla_lane_model.sv
`timescale 1ns/1ps
module hla_lane_model #(
    parameter logic [5:0] TRAIN_TAP = 6'h1b,
    parameter int         TRAIN_LEN = 6
) (
    input  wire logic                      word_clock,
    input  wire logic                      align_mode,
    input  wire logic                      train_ok,
    input  wire hla_pkg::hla_lane_ctl_type lane_ctl,
    output logic                           lane_lock,
    output logic [hla_pkg::TAP_W-1:0]      final_tap_readback,
    output logic [hla_pkg::WORD_W-1:0]     rx_word
);
    logic [hla_pkg::TAP_W-1:0]  tap = '0;
    logic [hla_pkg::WORD_W-1:0] tx_shadow = '0;
    int                         cnt = 0;
    initial lane_lock = 1'b0;
    initial rx_word = '0;
    // Debug pins carry junk until lock, never the last good value
    assign final_tap_readback = lane_lock ? tap : ~tap;
    always @(posedge word_clock) begin
        rx_word <= lane_ctl.rx_path_clear ? '0 : rx_word + 10'h001;
        tx_shadow <= lane_ctl.serializer_clear ? '0 : lane_ctl.tx_word;
        if (lane_ctl.counter_clear) begin
            tap <= '0;
            cnt <= 0;
            lane_lock <= 1'b0;
        end else if (align_mode) begin
            if (lane_ctl.step_enable && train_ok && !lane_lock) begin
                cnt <= cnt + 1;
                if (cnt == TRAIN_LEN - 1) begin
                    lane_lock <= 1'b1;
                    tap <= TRAIN_TAP;
                end
            end
        end else if (lane_ctl.step_enable) begin
            tap <= lane_ctl.step_up ? tap + 6'h01 : tap - 6'h01;
        end
    end
endmodule

// ===== tb/hla_lane_ctrl_tb.sv
`timescale 1ns/1ps
module hla_lane_ctrl_tb;
    logic                       sys_clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic                       word_clock = 1'b0;
    logic                       align_mode = 1'b0;
    logic                       train_ok = 1'b1;
    hla_pkg::hla_user_cmd_type  cmd = '0;
    hla_pkg::hla_lane_ctl_type  lane_ctl;
    logic                       lane_lock;
    logic [5:0]                 final_tap_readback;
    logic [5:0]                 tap_value;
    logic [9:0]                 rx_word;
    logic [9:0]                 rx_data;
    logic                       locked, tap_valid, rx_valid, step_done, lock_timeout, busy;
    logic [5:0]                 exp_tap;
    logic [9:0]                 first_word;
    int                         err_count = 0;
    int                         n_compared = 0;
    int                         i;
    always #12.5 sys_clk = ~sys_clk;
    always #100 word_clock = ~word_clock;
    hla_lane_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .word_clock(word_clock),
        .lane_lock(lane_lock), .final_tap_readback(final_tap_readback), .rx_word(rx_word),
        .cmd(cmd), .lane_ctl(lane_ctl), .locked(locked), .tap_value(tap_value),
        .tap_valid(tap_valid), .rx_data(rx_data), .rx_valid(rx_valid),
        .step_done(step_done), .lock_timeout(lock_timeout), .busy(busy));
    hla_lane_model M (.word_clock(word_clock), .align_mode(align_mode), .train_ok(train_ok),
        .lane_ctl(lane_ctl), .lane_lock(lane_lock), .final_tap_readback(final_tap_readback),
        .rx_word(rx_word));
    // ****************************************
    // Helpers
    // ****************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One-cycle command pulse, then all pulses low again
    task issue(input logic g, input logic s, input logic txc, input logic rxc);
        cmd.go <= g;
        cmd.step_req <= s;
        cmd.tx_clear_req <= txc;
        cmd.rx_clear_req <= rxc;
        tick(1);
        cmd.go <= 1'b0;
        cmd.step_req <= 1'b0;
        cmd.tx_clear_req <= 1'b0;
        cmd.rx_clear_req <= 1'b0;
        tick(1);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    // Values read at an edge are those launched by the edge before it
    task t_align;
        align_mode <= 1'b1;
        cmd.mode <= hla_pkg::MODE_ALIGN;
        issue(1'b1, 1'b0, 1'b0, 1'b0);
        tick(1);
        check(16'(lane_ctl.counter_clear), 16'h0001);
        check(16'(locked), 16'h0000);
        for (i = 0; i < 600 && locked !== 1'b1; i++) tick(1);
        check(16'(locked), 16'h0001);
        check(16'(tap_valid), 16'h0001);
        check(16'(tap_value), 16'(M.TRAIN_TAP));
    endtask
    // Step refused while locked, then again in static mode after a clear
    task t_refuse;
        issue(1'b0, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 40 && step_done !== 1'b1; i++) tick(1);
        check(16'(step_done), 16'h0000);
        cmd.mode <= hla_pkg::MODE_STATIC;
        issue(1'b1, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
        check(16'({locked, tap_valid}), 16'h0000);
        check(16'(M.tap), 16'h0000);
        issue(1'b0, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 40 && step_done !== 1'b1; i++) tick(1);
        check(16'({step_done, busy}), 16'h0000);
    endtask
    task t_step(input logic [3:0] dirs);
        align_mode <= 1'b0;
        cmd.mode <= hla_pkg::MODE_DYNAMIC;
        issue(1'b1, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
        exp_tap = 6'h00;
        check(16'(M.tap), 16'(exp_tap));
        for (int k = 0; k < 4; k++) begin
            cmd.step_dir <= dirs[k];
            exp_tap = dirs[k] ? exp_tap + 6'h01 : exp_tap - 6'h01;
            issue(1'b0, 1'b1, 1'b0, 1'b0);
            tick(1);
            check(16'(lane_ctl.step_up), 16'(dirs[k]));
            for (i = 0; i < 100 && step_done !== 1'b1; i++) tick(1);
            check(16'(step_done), 16'h0001);
            for (i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
        end
        check(16'(M.tap), 16'(exp_tap));
        cmd.clear_req <= 1'b1;
        tick(1);
        cmd.clear_req <= 1'b0;
        tick(1);
        for (i = 0; i < 300 && busy !== 1'b0; i++) tick(1);
        check(16'(M.tap), 16'h0000);
    endtask
    task t_rx;
        for (i = 0; i < 40 && rx_valid !== 1'b1; i++) tick(1);
        first_word = rx_data;
        tick(1);
        for (i = 0; i < 40 && rx_valid !== 1'b1; i++) tick(1);
        check(16'(rx_data), 16'(first_word + 10'h001));
    endtask
    task t_clears;
        cmd.tx_word <= 10'h2a5;
        // Word taken at a word edge, then by the lane one word later
        tick(24);
        check(16'(lane_ctl.tx_word), 16'h02a5);
        check(16'(M.tx_shadow), 16'h02a5);
        issue(1'b0, 1'b0, 1'b1, 1'b0);
        for (i = 0; i < 20 && lane_ctl.serializer_clear !== 1'b1; i++) tick(1);
        check(16'(lane_ctl.serializer_clear), 16'h0001);
        tick(10);
        check(16'(M.tx_shadow), 16'h0000);
        issue(1'b0, 1'b0, 1'b0, 1'b1);
        for (i = 0; i < 20 && lane_ctl.rx_path_clear !== 1'b1; i++) tick(1);
        check(16'(lane_ctl.rx_path_clear), 16'h0001);
        tick(10);
        check(16'(M.rx_word), 16'h0000);
    endtask
    task t_timeout;
        train_ok <= 1'b0;
        align_mode <= 1'b1;
        cmd.mode <= hla_pkg::MODE_ALIGN;
        issue(1'b1, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 9000 && lock_timeout !== 1'b1; i++) tick(1);
        check(16'(lock_timeout), 16'h0001);
        check(16'(locked), 16'h0000);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        tick(6);
        check(16'(lane_ctl), 16'h0000);
        check(16'({locked, busy, rx_valid}), 16'h0000);
        rst_n <= 1'b1;
        tick(1);
        t_align();
        t_refuse();
        t_align();
        t_step(4'b1011);
        t_rx();
        t_clears();
        t_timeout();
        conclude();
    end
    // Longest path is the lock timeout, about 8200 cycles
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
endmodule
